// ===== bench/bct_slave.sv
`timescale 1ns/10ps
`default_nettype none

// Far-side slave: one queued termination code per
// bus termination (0 normal ack, 1 error ack, 2 both). Pins idle high.
module bct_slave (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       active,
  input  wire logic [1:0] delay,
  output logic            transfer_ack_n,
  output logic            transfer_error_ack_n
);
  logic [1:0] terms[$];
  logic [1:0] code;

  // Answer a live cycle after some wait states, one sampled edge only
  initial begin
    transfer_ack_n = 1'b1;
    transfer_error_ack_n = 1'b1;
    forever begin
      @(posedge mclk);
      if (!rst && active === 1'b1 && terms.size() > 0) begin
        repeat (delay) @(posedge mclk); // Slow answer
        code = terms.pop_front();
        transfer_ack_n <= (code == 2'h1); // Normal acknowledge for codes 0 and 2
        transfer_error_ack_n <= (code == 2'h0); // Error acknowledge for codes 1 and 2
        @(posedge mclk);
        transfer_ack_n <= 1'b1; // Released after one edge
        transfer_error_ack_n <= 1'b1;
        repeat (4) @(posedge mclk);
      end
    end
  end
endmodule

`default_nettype wire

// ===== bench/bus_cycle_termination_error_tb.sv
`timescale 1ns/10ps
`default_nettype none

module bus_cycle_termination_error_tb;
  logic          mclk = 1'b0;
  logic          rst = 1'b1;
  logic          req_valid = 1'b0;
  bct_pkg::req_t rq = '0;
  logic          snoop_kill = 1'b0;
  logic          fetch_used = 1'b0;
  logic          fetch_flush = 1'b0;
  logic [1:0]    slow = 2'h0;
  logic          ta_n;
  logic          tea_n;
  logic          req_ready;
  logic          fault_pending;
  bct_pkg::bus_t bus;
  bct_pkg::res_t res;
  logic [9:0]    exp_q[$];
  logic [31:0]   rnd = 32'h573B;
  int            fail_count = 0;
  int            tests_run = 0;
  int            done_count = 0;
  int            cyc = 0;

  // Clock generation
  always #12.5 mclk = ~mclk;

  bus_cycle_termination_error dut (
    .mclk(mclk), .rst(rst), .req_valid(req_valid), .req(rq),
    .transfer_ack_n(ta_n), .transfer_error_ack_n(tea_n),
    .snoop_kill(snoop_kill), .fetch_used(fetch_used),
    .fetch_flush(fetch_flush), .req_ready(req_ready), .bus(bus),
    .res(res), .fault_pending(fault_pending)
  );

  bct_slave slave (
    .mclk(mclk), .rst(rst), .active(bus.active), .delay(slow),
    .transfer_ack_n(ta_n), .transfer_error_ack_n(tea_n)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task summarize;
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog, done counter, and result pulses against the oldest note
  always @(posedge mclk) begin
    cyc++;
    if (!rst && res.done === 1'b1) done_count++;
    if (!rst && (res & 10'h1FF) !== 10'h000) begin
      if (exp_q.size() == 0) check("res", 32'h0, {22'h0, res & 10'h1FF});
      else check("res", {22'h0, exp_q.pop_front()}, {22'h0, res & 10'h1FF});
    end
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end

  // One access: queue terminations and notes, issue, check attributes
  task automatic run(input bct_pkg::kind_t k, input logic [1:0] want,
      input logic [3:0] fl, input logic [7:0] tc, input int n,
      input logic [9:0] e1, input logic [9:0] e2, input logic dn);
    int d0;
    logic [31:0] a;
    logic wr;
    for (int t = 0; t < n; t++) slave.terms.push_back(tc[2*t +: 2]);
    if (e1 != 10'h000) exp_q.push_back(e1);
    if (e2 != 10'h000) exp_q.push_back(e2);
    rnd = lfsr(rnd);
    a = (k == bct_pkg::K_BREAKPOINT_INSTRUCTION) ? 32'h0 : {rnd[31:4], 4'h0};
    @(posedge mclk);
    rq <= '{k, {rnd[31:4], 4'h0}, rnd[1:0], rnd[6:4], want, fl[3], fl[2], fl[1], fl[0]};
    slow <= rnd[9:8];
    req_valid <= 1'b1;
    d0 = done_count;
    @(posedge mclk);
    req_valid <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    check("addr", a, bus.address_lines);
    if (k == bct_pkg::K_BREAKPOINT_INSTRUCTION) a = 32'h18;
    else a = {27'h0, rnd[1:0], rnd[6:4]};
    check("tt_tm", a, {27'h0, bus.transfer_type_hi, bus.transfer_type_lo,
      bus.transfer_modifier});
    wr = (k == bct_pkg::K_WRITE) || (k == bct_pkg::K_WT_WRITE) ||
         (k == bct_pkg::K_LINE_PUSH);
    check("write", {31'h0, wr}, {31'h0, bus.write});
    for (int w = 0; w < 300 && !(req_ready === 1'b1 && bus.active === 1'b0); w++)
      @(posedge mclk);
    check("idle", 32'h1, {31'h0, req_ready === 1'b1 && bus.active === 1'b0});
    repeat (2) @(posedge mclk);
    if (dn) check("done", d0 + 1, done_count);
  endtask

  task pulse(input logic used);
    @(posedge mclk);
    if (used) fetch_used <= 1'b1;
    else fetch_flush <= 1'b1;
    @(posedge mclk);
    fetch_used <= 1'b0;
    fetch_flush <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    check("ready", 32'h1, {31'h0, req_ready});
    run(bct_pkg::K_READ, 2'h0, 4'h0, 8'h00, 1, 10'h000, 10'h000, 1'b1);
    run(bct_pkg::K_READ, 2'h0, 4'h0, 8'h02, 2, 10'h100, 10'h000, 1'b1);
    run(bct_pkg::K_WRITE, 2'h0, 4'h0, 8'h01, 1, 10'h080, 10'h000, 1'b0);
    run(bct_pkg::K_BREAKPOINT_INSTRUCTION, 2'h0, 4'h0, 8'h00, 1, 10'h040, 10'h000, 1'b1);
    run(bct_pkg::K_BREAKPOINT_INSTRUCTION, 2'h0, 4'h0, 8'h01, 1, 10'h040, 10'h000, 1'b0);
    run(bct_pkg::K_LINE_READ, 2'h2, 4'h6, 8'h04, 2, 10'h008, 10'h014, 1'b0);
    run(bct_pkg::K_LINE_READ, 2'h2, 4'h0, 8'h10, 3, 10'h080, 10'h000, 1'b0);
    run(bct_pkg::K_LINE_READ, 2'h3, 4'h8, 8'h04, 2, 10'h080, 10'h000, 1'b0);
    run(bct_pkg::K_LINE_READ, 2'h3, 4'h0, 8'h08, 2, 10'h010, 10'h000, 1'b0);
    run(bct_pkg::K_LINE_READ, 2'h0, 4'h0, 8'h00, 4, 10'h000, 10'h000, 1'b1);
    run(bct_pkg::K_LINE_PUSH, 2'h0, 4'h1, 8'h01, 1, 10'h088, 10'h000, 1'b0);
    run(bct_pkg::K_LINE_PUSH, 2'h0, 4'h0, 8'h01, 1, 10'h082, 10'h000, 1'b0);
    run(bct_pkg::K_WT_WRITE, 2'h0, 4'h0, 8'h01, 1, 10'h001, 10'h082, 1'b0);
    run(bct_pkg::K_FETCH, 2'h0, 4'h0, 8'h01, 1, 10'h000, 10'h000, 1'b0);
    check("pend", 32'h1, {31'h0, fault_pending});
    exp_q.push_back(10'h020);
    pulse(1'b1);
    check("pend", 32'h0, {31'h0, fault_pending});
    run(bct_pkg::K_FETCH, 2'h0, 4'h0, 8'h01, 1, 10'h000, 10'h000, 1'b0);
    pulse(1'b0);
    check("pend", 32'h0, {31'h0, fault_pending});
    pulse(1'b1);
    snoop_kill <= 1'b1;
    run(bct_pkg::K_LINE_PUSH, 2'h0, 4'h0, 8'h02, 1, 10'h000, 10'h000, 1'b1);
    snoop_kill <= 1'b0;
    repeat (5) @(posedge mclk);
    check("queue", 32'h0, exp_q.size());
    summarize();
  end
endmodule

`default_nettype wire

// ===== verilog/bct_defines.svh
`ifndef BCT_DEFINES_SVH
`define BCT_DEFINES_SVH

// Transfer type codes
`define BCT_TT_NORMAL 2'h0
`define BCT_TT_ACK    2'h3

// Breakpoint acknowledge attributes
`define BCT_BREAKPOINT_INSTRUCTION_ADDR 32'h00000000
`define BCT_BREAKPOINT_INSTRUCTION_TM   3'h0

// Line transfer beats, first, second and last index
`define BCT_BEAT_FIRST 2'h0
`define BCT_BEAT_SECOND 2'h1
`define BCT_BEAT_LAST  2'h3

// Longword select field within a line address
`define BCT_BEAT_LSB 2
`define BCT_BEAT_MSB 3

// Reset values
`define BCT_RST_ADDR 32'h00000000
`define BCT_RST_TM   3'h0

`endif

// ===== verilog/bct_pkg.sv
package bct_pkg;

  // Kind of access the core hands over
  typedef enum logic [2:0] {
    K_READ, K_WRITE, K_LINE_READ, K_LINE_PUSH,
    K_WT_WRITE, K_FETCH, K_BREAKPOINT_INSTRUCTION
  } kind_t;

  // Controller states
  typedef enum logic [1:0] {S_IDLE, S_PREP, S_RUN} state_t;

  // Access request from the core
  typedef struct packed {
    kind_t       kind;
    logic [31:0] addr;
    logic [1:0]  tt;
    logic [2:0]  tm;
    logic [1:0]  want_beat;
    logic        span;
    logic        replace_valid;
    logic        replace_dirty;
    logic        forced_push;
  } req_t;

  // External bus outputs
  typedef struct packed {
    logic        active;
    logic        write;
    logic [31:0] address_lines;
    logic        transfer_type_hi;
    logic        transfer_type_lo;
    logic [2:0]  transfer_modifier;
  } bus_t;

  // One-cycle result pulses
  typedef struct packed {
    logic done;
    logic retried;
    logic access_err;
    logic illegal_exc;
    logic fetch_fault;
    logic fill_drop;
    logic line_inval;
    logic line_restore;
    logic line_keep;
    logic line_update;
  } res_t;

endpackage

// ===== verilog/bus_cycle_termination_error.sv
`timescale 1ns/10ps
`default_nettype none
`include "bct_defines.svh"

// Operation
// - Breakpoint runs acknowledge cycle, type 3, address zero, modifier zero.
// - Breakpoint cycle ended by either acknowledge gives illegal instruction exception.
// - Error alone ends cycle as bus error, exception possibly deferred.
// - Both acknowledges together end the cycle and retry it.
// - Normal acknowledge alone completes; neither inserts a wait and resamples.
// - Bus error ends access at once; line abandons remaining beats.
// - Prefetch error raises exception only when used; dropped on branch.
// - Line read error on beats 2-4 reported only if that longword requested.
// - Unreported line read error: line not cached, refetched later.
// - Spanning operand error on first or second beat is reported immediately.
// - Error on any write or requested read is reported immediately.
// - Line being replaced is invalidated before fill; stays invalid on error.
// - Dirty line restored from push buffer when replacement read errors.
// - Push error keeps line valid after replacement, invalidates if forced push.
// - Write-through updates cache first; line stays valid on write error.
// - State-save bus error corrupts saved frame; no protection is given.
// - Retry reruns same address and attributes unless snoop killed the push.
// - Retry on beats 2-4 of a line is a bus error and aborts.
module bus_cycle_termination_error (
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire logic          req_valid,
  input  wire bct_pkg::req_t req,
  input  wire logic          transfer_ack_n,
  input  wire logic          transfer_error_ack_n,
  input  wire logic          snoop_kill,
  input  wire logic          fetch_used,
  input  wire logic          fetch_flush,
  output logic               req_ready,
  output bct_pkg::bus_t      bus,
  output bct_pkg::res_t      res,
  output logic               fault_pending
);

  bct_pkg::state_t state;
  bct_pkg::state_t next_state;
  bct_pkg::req_t   cur;
  bct_pkg::req_t   next_cur;
  bct_pkg::bus_t   next_bus;
  bct_pkg::res_t   next_res;
  logic [1:0]      beat;
  logic [1:0]      next_beat;
  logic            next_req_ready;
  logic            next_fault_pending;
  logic [1:0]      ack_meta;
  logic [1:0]      ack_sync;
  logic            ta;
  logic            transfer_error_ack;
  logic            is_line;
  logic            is_write;
  logic            report;

  // Pin synchronisers, active-low pins turned active-high
  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_meta <= 2'h0;
      ack_sync <= 2'h0;
    end else begin
      ack_meta <= {~transfer_error_ack_n, ~transfer_ack_n};
      ack_sync <= ack_meta;
    end
  end

  assign ta  = ack_sync[0];
  assign transfer_error_ack = ack_sync[1];

  // Access classification
  assign is_line  = (cur.kind == bct_pkg::K_LINE_READ) ||
                    (cur.kind == bct_pkg::K_LINE_PUSH);
  assign is_write = (cur.kind == bct_pkg::K_WRITE) ||
                    (cur.kind == bct_pkg::K_WT_WRITE) ||
                    (cur.kind == bct_pkg::K_LINE_PUSH);

  // Line read error is reported on first beat, requested beat or span
  assign report = (beat == `BCT_BEAT_FIRST) || (beat == cur.want_beat) ||
                  (cur.span && (beat == `BCT_BEAT_SECOND));

  // Next-state logic of the termination controller
  always_comb begin
    next_state         = state;
    next_cur           = cur;
    next_bus           = bus;
    next_res           = '0;
    next_beat          = beat;
    next_req_ready     = req_ready;
    next_fault_pending = fault_pending;
    if (fetch_used && fault_pending) begin
      next_res.fetch_fault = 1'b1;
    end
    if (fetch_used || fetch_flush) begin
      next_fault_pending = 1'b0;
    end
    unique case (state)
      bct_pkg::S_IDLE: begin
        if (req_valid) begin
          next_cur       = req;
          next_beat      = `BCT_BEAT_FIRST;
          next_req_ready = 1'b0;
          next_bus.write = (req.kind == bct_pkg::K_WRITE) ||
                           (req.kind == bct_pkg::K_WT_WRITE) ||
                           (req.kind == bct_pkg::K_LINE_PUSH);
          next_bus.address_lines = req.addr;
          {next_bus.transfer_type_hi, next_bus.transfer_type_lo} = req.tt;
          next_bus.transfer_modifier = req.tm;
          if (req.kind == bct_pkg::K_BREAKPOINT_INSTRUCTION) begin
            next_bus.address_lines = `BCT_BREAKPOINT_INSTRUCTION_ADDR;
            {next_bus.transfer_type_hi, next_bus.transfer_type_lo} = `BCT_TT_ACK;
            next_bus.transfer_modifier = `BCT_BREAKPOINT_INSTRUCTION_TM;
          end
          if ((req.kind == bct_pkg::K_LINE_READ && req.replace_valid) ||
              req.kind == bct_pkg::K_WT_WRITE) begin
            next_state = bct_pkg::S_PREP;
          end else begin
            next_state      = bct_pkg::S_RUN;
            next_bus.active = 1'b1;
          end
        end
      end
      bct_pkg::S_PREP: begin
        // Cache touched in the same cycle the bus cycle starts
        next_res.line_inval  = (cur.kind == bct_pkg::K_LINE_READ);
        next_res.line_update = (cur.kind == bct_pkg::K_WT_WRITE);
        next_state           = bct_pkg::S_RUN;
        next_bus.active      = 1'b1;
      end
      bct_pkg::S_RUN: begin
        if (ta && transfer_error_ack && !(is_line && beat != `BCT_BEAT_FIRST)) begin
          if (cur.kind == bct_pkg::K_LINE_PUSH && snoop_kill) begin
            // Snooped push is dropped instead of rerun
            next_res.done   = 1'b1;
            next_state      = bct_pkg::S_IDLE;
            next_bus.active = 1'b0;
            next_req_ready  = 1'b1;
          end else begin
            next_res.retried = 1'b1;
          end
        end else if (transfer_error_ack) begin
          // Bus error, or late line retry treated as one
          next_res.done   = 1'b1;
          next_state      = bct_pkg::S_IDLE;
          next_bus.active = 1'b0;
          next_req_ready  = 1'b1;
          unique case (cur.kind)
            bct_pkg::K_BREAKPOINT_INSTRUCTION:      next_res.illegal_exc = 1'b1;
            bct_pkg::K_FETCH:     next_fault_pending = 1'b1;
            bct_pkg::K_LINE_READ: begin
              next_res.access_err   = report;
              next_res.fill_drop    = !report;
              next_res.line_restore = cur.replace_dirty;
            end
            bct_pkg::K_LINE_PUSH: begin
              next_res.access_err = 1'b1;
              next_res.line_inval = cur.forced_push;
              next_res.line_keep  = !cur.forced_push;
            end
            bct_pkg::K_WT_WRITE: begin
              next_res.access_err = 1'b1;
              next_res.line_keep  = 1'b1;
            end
            // State-save stores end here too; a failed one leaves a corrupt frame
            default: next_res.access_err = 1'b1;
          endcase
        end else if (ta) begin
          if (is_line && beat != `BCT_BEAT_LAST) begin
            // Next longword of the line
            next_beat = beat + 2'h1;
            next_bus.address_lines[`BCT_BEAT_MSB:`BCT_BEAT_LSB] =
              bus.address_lines[`BCT_BEAT_MSB:`BCT_BEAT_LSB] + 2'h1;
          end else begin
            next_res.done        = 1'b1;
            next_res.illegal_exc = (cur.kind == bct_pkg::K_BREAKPOINT_INSTRUCTION);
            next_state           = bct_pkg::S_IDLE;
            next_bus.active      = 1'b0;
            next_req_ready       = 1'b1;
          end
        end
        // Neither acknowledge: wait and resample
      end
    endcase
  end

  // State registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      state     <= bct_pkg::S_IDLE;
      cur       <= '0;
      beat      <= `BCT_BEAT_FIRST;
      req_ready <= 1'b1;
      res       <= '0;
      fault_pending <= 1'b0;
      bus.active    <= 1'b0;
      bus.write     <= 1'b0;
      bus.address_lines <= `BCT_RST_ADDR;
      {bus.transfer_type_hi, bus.transfer_type_lo} <= `BCT_TT_NORMAL;
      bus.transfer_modifier <= `BCT_RST_TM;
    end else begin
      state         <= next_state;
      cur           <= next_cur;
      beat          <= next_beat;
      req_ready     <= next_req_ready;
      res           <= next_res;
      fault_pending <= next_fault_pending;
      bus           <= next_bus;
    end
  end

  // Checks on the controller
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  breakpoint_instruction_bus_a: assert property (
    state == bct_pkg::S_RUN && cur.kind == bct_pkg::K_BREAKPOINT_INSTRUCTION |->
      bus.address_lines == `BCT_BREAKPOINT_INSTRUCTION_ADDR && bus.transfer_type_hi &&
      bus.transfer_type_lo && bus.transfer_modifier == `BCT_BREAKPOINT_INSTRUCTION_TM)
    else $error("breakpoint cycle attributes wrong");

  breakpoint_instruction_illegal_a: assert property (
    state == bct_pkg::S_RUN && cur.kind == bct_pkg::K_BREAKPOINT_INSTRUCTION && (ta || transfer_error_ack) &&
      !(ta && transfer_error_ack) |=> res.illegal_exc && res.done)
    else $error("breakpoint did not raise illegal exception");

  done_cause_a: assert property (
    res.done |-> $past(ta) || $past(transfer_error_ack))
    else $error("cycle completed without acknowledge");

  bus_error_a: assert property (
    state == bct_pkg::S_RUN && transfer_error_ack && !ta |=>
      state == bct_pkg::S_IDLE && res.done && !bus.active)
    else $error("bus error did not end cycle");

  retry_same_a: assert property (
    state == bct_pkg::S_RUN && ta && transfer_error_ack && beat == `BCT_BEAT_FIRST &&
      !snoop_kill |=> res.retried && state == bct_pkg::S_RUN &&
      $stable(bus.address_lines) ##1 bus.active)
    else $error("retry did not rerun same cycle");

  wait_state_a: assert property (
    state == bct_pkg::S_RUN && !ta && !transfer_error_ack |=>
      state == bct_pkg::S_RUN && !res.done && bus.active)
    else $error("wait state not inserted");

  late_retry_a: assert property (
    state == bct_pkg::S_RUN && is_line && beat != `BCT_BEAT_FIRST &&
      ta && transfer_error_ack |=> !res.retried && state == bct_pkg::S_IDLE)
    else $error("late line retry not aborted");

  fetch_defer_a: assert property (
    state == bct_pkg::S_RUN && cur.kind == bct_pkg::K_FETCH && transfer_error_ack && !ta
      |=> fault_pending && !res.access_err)
    else $error("prefetch error not deferred");

  write_error_a: assert property (
    state == bct_pkg::S_RUN && is_write && transfer_error_ack && !ta |=> res.access_err)
    else $error("write error not reported at once");

  fill_drop_a: assert property (
    res.fill_drop |-> !res.access_err)
    else $error("dropped fill also reported");

  inval_first_a: assert property (
    state == bct_pkg::S_PREP && cur.kind == bct_pkg::K_LINE_READ |=>
      res.line_inval && bus.active)
    else $error("line not invalidated before fill");

  restore_dirty_a: assert property (
    state == bct_pkg::S_RUN && cur.kind == bct_pkg::K_LINE_READ && cur.replace_dirty &&
      transfer_error_ack && !ta |=> res.line_restore)
    else $error("dirty line not restored after failed fill");

  push_error_a: assert property (
    state == bct_pkg::S_RUN && cur.kind == bct_pkg::K_LINE_PUSH && transfer_error_ack && !ta |=>
      res.line_inval == cur.forced_push && res.line_keep == !cur.forced_push)
    else $error("pushed line left in wrong state");

  wt_keep_a: assert property (
    state == bct_pkg::S_RUN && cur.kind == bct_pkg::K_WT_WRITE && transfer_error_ack && !ta |=>
      res.line_keep && !res.line_inval)
    else $error("write-through line not kept valid");

  wanted_beat_a: assert property (
    state == bct_pkg::S_RUN && cur.kind == bct_pkg::K_LINE_READ && transfer_error_ack && !ta &&
      beat == cur.want_beat |=> res.access_err && !res.fill_drop)
    else $error("requested longword error not reported");

  unwanted_beat_a: assert property (
    state == bct_pkg::S_RUN && cur.kind == bct_pkg::K_LINE_READ && transfer_error_ack && !ta &&
      beat != `BCT_BEAT_FIRST && beat != cur.want_beat &&
      !(cur.span && beat == `BCT_BEAT_SECOND) |=> res.fill_drop && !res.access_err)
    else $error("unrequested longword error not dropped");

  fault_clear_a: assert property (
    (fetch_used || fetch_flush) && !(state == bct_pkg::S_RUN && transfer_error_ack) |=> !fault_pending)
    else $error("prefetch fault not cleared");

  fault_use_a: assert property (
    fetch_used && fault_pending |=> res.fetch_fault)
    else $error("used prefetch fault not raised");

endmodule
`default_nettype wire
